// ===== rtl/fes_cfg.svh
// Register map, field positions, reset values and timing figures
// Assumes a 200 MHz CPU clock
`ifndef FES_CFG_SVH
`define FES_CFG_SVH

// Clock rate in MHz
`define FES_CLK_MHZ 200
// Least supply gap taken as power interruption, in us
`define FES_PWR_LOSS_US 10000
// Cycle monitor tick, in us
`define FES_TICK_US 1

// Byte offsets on the register bus
`define FES_OFS_CTRL 5'h00
`define FES_OFS_CYCLIM 5'h04
`define FES_OFS_STATUS 5'h08
`define FES_OFS_MEMFLG 5'h0C
`define FES_OFS_IOLOC 5'h10
`define FES_OFS_IRQST 5'h14
`define FES_OFS_IRQEN 5'h18
`define FES_OFS_IRQCLR 5'h1C

// Reset values
`define FES_CYCLIM_RST 16'h0000
`define FES_IRQEN_RST 2'h0

// Fatal codes and classification bytes
`define FES_CODE_NONE 8'h00
`define FES_CODE_MEM 8'hF1
`define FES_CODE_NOEND 8'hF0
`define FES_CODE_IOBUS 8'hC0
`define FES_CODE_IOOVR 8'hE1
`define FES_CODE_CYC 8'h9F
`define FES_CLASS_NONFATAL 8'h00
`define FES_CLASS_FATAL 8'h80

// Cause flag positions in the memory flag word
`define FES_A_SETUP 11
`define FES_A_PROG 12
`define FES_A_EXP 13
`define FES_A_CASS 14
`define FES_A_CASSRD 15
`define FES_B_UNDEF 8
`define FES_B_FLASH 9
`define FES_B_RODM 10
`define FES_B_SETUP 11
`define FES_B_PROG 12
`define FES_B_HOLD 14
`define FES_B_RBUS 15
// I/O location flags occupy bits 15:8
`define FES_IOLOC_LSB 8

// Interrupt bits
`define FES_IRQ_FATAL 0
`define FES_IRQ_PWR 1

`endif

// ===== rtl/fes_pkg.sv
// Types shared by the fatal-error supervisor
// Constants live in fes_cfg.svh
package fes_pkg;
    typedef enum logic {
        FES_RUN,
        FES_HALT
    } fes_state_t;
    typedef enum logic {
        FES_VAR_A,
        FES_VAR_B
    } fes_variant_t;
endpackage

// ===== rtl/fes_supervisor.sv
// Fatal-error supervisor: detects fatal causes, halts, forces outputs off
// Assumes cause inputs come from logic on clk; only powerOk is a pin
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
`include "fes_cfg.svh"

module fes_supervisor #(
    parameter int PWR_LOSS_CYC = `FES_PWR_LOSS_US * `FES_CLK_MHZ,
    parameter int CYC_W = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic powerOk,
    input wire logic cycleStart,
    input wire logic setupCsErr,
    input wire logic progCsErr,
    input wire logic expCsErr,
    input wire logic cassetteSwap,
    input wire logic cassetteReadErr,
    input wire logic undefBitArea,
    input wire logic flashWearOut,
    input wire logic roDataCsErr,
    input wire logic holdAreaLost,
    input wire logic remoteBusErr,
    input wire logic missingTerminator,
    input wire logic ioBusErr,
    input wire logic [7:0] ioBusLoc,
    input wire logic ioWordOverflow,
    input wire logic fatalAlarmInstruction,
    input wire logic [7:0] fatalAlarmOperand,
    output logic runEnable,
    output logic outputsEnable,
    output logic ledPower,
    output logic ledRun,
    output logic errorAlarmIndicator,
    output logic fatal,
    output logic [7:0] fatalCode,
    output logic [7:0] fatalClass,
    output logic irq
);
    localparam int TICK_CYC = `FES_TICK_US * `FES_CLK_MHZ;
    localparam int PWR_W = $clog2(PWR_LOSS_CYC + 1);
    localparam int TICK_W = $clog2(TICK_CYC + 1);

    fes_pkg::fes_state_t state_r;
    fes_pkg::fes_variant_t variant_r;
    logic pwrMeta_r, pwrSync_r;
    logic [PWR_W-1:0] pwrCnt_r;
    logic pwrFatal_r;
    logic [TICK_W-1:0] tickCnt_r;
    logic [CYC_W-1:0] cycCnt_r, cycLimit_r;
    logic [15:0] memFlags_r;
    logic [15:0] ioLoc_r;
    logic [7:0] code_r, class_r;
    logic [1:0] irqSt_r, irqEn_r;
    logic ack_r;
    logic [31:0] rdata_r;

    logic pwrLost, memFault, cycOver, falsOk, anyFatal;
    logic [7:0] codeNxt;
    logic [15:0] memSet;
    logic [1:0] irqEv;
    logic access, xfer;

    // Supply pin crosses in through two flops
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pwrMeta_r <= 1'b1;
            pwrSync_r <= 1'b1;
        end else begin
            pwrMeta_r <= powerOk;
            pwrSync_r <= pwrMeta_r;
        end
    end

    // Supply gap timer; short dips shorter than the limit are ignored
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pwrCnt_r <= '0;
        end else if (pwrSync_r) begin
            pwrCnt_r <= '0;
        end else if (pwrCnt_r < PWR_W'(PWR_LOSS_CYC)) begin
            pwrCnt_r <= pwrCnt_r + 1'b1;
        end
    end

    assign pwrLost = !pwrSync_r && (pwrCnt_r >= PWR_W'(PWR_LOSS_CYC - 1));

    // Microsecond tick for the cycle monitor
    always_ff @(posedge clk) begin
        if (!rstn || tickCnt_r == TICK_W'(TICK_CYC - 1)) begin
            tickCnt_r <= '0;
        end else begin
            tickCnt_r <= tickCnt_r + 1'b1;
        end
    end

    // Cycle length in ticks, restarted by each program cycle
    always_ff @(posedge clk) begin
        if (!rstn || cycleStart) begin
            cycCnt_r <= '0;
        end else if (tickCnt_r == TICK_W'(TICK_CYC - 1) && cycCnt_r != '1) begin
            cycCnt_r <= cycCnt_r + 1'b1;
        end
    end

    // Zero limit disables the monitor
    assign cycOver = (cycLimit_r != '0) && (cycCnt_r > cycLimit_r);

    // Operand must be two BCD digits, 01 to 99
    assign falsOk = fatalAlarmInstruction && (fatalAlarmOperand[7:4] <= 4'h9)
        && (fatalAlarmOperand[3:0] <= 4'h9) && (fatalAlarmOperand != 8'h00);

    // Memory cause flags per variant
    always_comb begin
        memSet = '0;
        if (variant_r == fes_pkg::FES_VAR_A) begin
            memSet[`FES_A_SETUP] = setupCsErr;
            memSet[`FES_A_PROG] = progCsErr;
            memSet[`FES_A_EXP] = expCsErr;
            memSet[`FES_A_CASS] = cassetteSwap;
            memSet[`FES_A_CASSRD] = cassetteReadErr;
        end else begin
            memSet[`FES_B_UNDEF] = undefBitArea;
            memSet[`FES_B_FLASH] = flashWearOut;
            memSet[`FES_B_RODM] = roDataCsErr;
            memSet[`FES_B_SETUP] = setupCsErr;
            memSet[`FES_B_PROG] = progCsErr;
            memSet[`FES_B_HOLD] = holdAreaLost;
            memSet[`FES_B_RBUS] = remoteBusErr;
        end
    end

    assign memFault = |memSet;

    // Priority when causes coincide: supply, memory, terminator, bus,
    // overflow, cycle, alarm instruction
    always_comb begin
        codeNxt = `FES_CODE_NONE;
        if (pwrLost) begin
            codeNxt = `FES_CODE_NONE;
        end else if (memFault) begin
            codeNxt = `FES_CODE_MEM;
        end else if (missingTerminator) begin
            codeNxt = `FES_CODE_NOEND;
        end else if (ioBusErr) begin
            codeNxt = `FES_CODE_IOBUS;
        end else if (ioWordOverflow) begin
            codeNxt = `FES_CODE_IOOVR;
        end else if (cycOver) begin
            codeNxt = `FES_CODE_CYC;
        end else if (falsOk) begin
            codeNxt = fatalAlarmOperand;
        end
    end

    assign anyFatal = pwrLost || memFault || missingTerminator || ioBusErr
        || ioWordOverflow || cycOver || falsOk;

    // Halt is final; only reset leaves it
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r <= fes_pkg::FES_RUN;
            code_r <= `FES_CODE_NONE;
            class_r <= `FES_CLASS_NONFATAL;
            pwrFatal_r <= 1'b0;
        end else begin
            unique case (state_r)
                fes_pkg::FES_RUN: begin
                    if (anyFatal) begin
                        state_r <= fes_pkg::FES_HALT;
                        code_r <= codeNxt;
                        class_r <= `FES_CLASS_FATAL;
                        pwrFatal_r <= pwrLost;
                    end
                end
                fes_pkg::FES_HALT: begin
                    state_r <= fes_pkg::FES_HALT;
                end
            endcase
        end
    end

    // Cause flags are sticky; later causes still add their flags
    always_ff @(posedge clk) begin
        if (!rstn) begin
            memFlags_r <= '0;
        end else begin
            memFlags_r <= memFlags_r | memSet;
        end
    end

    // Bus location flags kept only in variant A
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ioLoc_r <= '0;
        end else if (ioBusErr && variant_r == fes_pkg::FES_VAR_A) begin
            ioLoc_r[`FES_IOLOC_LSB +: 8] <= ioLoc_r[`FES_IOLOC_LSB +: 8] | ioBusLoc;
        end
    end

    assign fatal = (state_r == fes_pkg::FES_HALT);
    assign runEnable = !fatal;
    assign outputsEnable = !fatal;
    assign ledPower = !(fatal && pwrFatal_r);
    assign ledRun = !fatal;
    assign errorAlarmIndicator = fatal && !pwrFatal_r;
    assign fatalCode = code_r;
    assign fatalClass = class_r;

    // Interrupt status: set wins over a clear in the same cycle
    assign irqEv[`FES_IRQ_FATAL] = (state_r == fes_pkg::FES_RUN) && anyFatal;
    assign irqEv[`FES_IRQ_PWR] = (state_r == fes_pkg::FES_RUN) && pwrLost;
    assign access = (read || write) && !ack_r;
    // Writes land only on the edge that completes the transfer
    assign xfer = (read || write) && ack_r;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irqSt_r <= '0;
        end else if (xfer && write && address == `FES_OFS_IRQCLR) begin
            irqSt_r <= (irqSt_r & ~writedata[1:0]) | irqEv;
        end else begin
            irqSt_r <= irqSt_r | irqEv;
        end
    end

    assign irq = |(irqSt_r & irqEn_r);

    // Avalon slave: one wait state, answer on the second edge
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= access;
        end
    end

    assign waitrequest = (read || write) && !ack_r;

    // Writable registers; variant change is honoured even while halted
    always_ff @(posedge clk) begin
        if (!rstn) begin
            variant_r <= fes_pkg::FES_VAR_A;
            cycLimit_r <= `FES_CYCLIM_RST;
            irqEn_r <= `FES_IRQEN_RST;
        end else if (xfer && write) begin
            unique case (address)
                `FES_OFS_CTRL: variant_r <= fes_pkg::fes_variant_t'(writedata[0]);
                `FES_OFS_CYCLIM: cycLimit_r <= writedata[CYC_W-1:0];
                `FES_OFS_IRQEN: irqEn_r <= writedata[1:0];
                default: begin
                end
            endcase
        end
    end

    // Read data, unmapped and write-only offsets read zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_r <= '0;
        end else if (access && read) begin
            rdata_r <= '0;
            unique case (address)
                `FES_OFS_CTRL: rdata_r[0] <= variant_r;
                `FES_OFS_CYCLIM: rdata_r[CYC_W-1:0] <= cycLimit_r;
                `FES_OFS_STATUS: rdata_r <= {5'h00, errorAlarmIndicator, ledRun,
                    ledPower, class_r, code_r, 6'h00, pwrFatal_r, fatal};
                `FES_OFS_MEMFLG: rdata_r[15:0] <= memFlags_r;
                `FES_OFS_IOLOC: rdata_r[15:0] <= ioLoc_r;
                `FES_OFS_IRQST: rdata_r[1:0] <= irqSt_r;
                `FES_OFS_IRQEN: rdata_r[1:0] <= irqEn_r;
                default: rdata_r <= '0;
            endcase
        end
    end

    assign readdata = rdata_r;

    // Checks
    property p_halt_on_fatal;
        @(posedge clk) disable iff (!rstn)
        (state_r == fes_pkg::FES_RUN && anyFatal) |=> fatal && !outputsEnable && !runEnable;
    endproperty
    a_halt_on_fatal: assert property (p_halt_on_fatal)
        else $error("fatal cause did not halt");

    property p_pwr_leds;
        @(posedge clk) disable iff (!rstn)
        (fatal && pwrFatal_r) |-> !ledPower && !ledRun && !errorAlarmIndicator;
    endproperty
    a_pwr_leds: assert property (p_pwr_leds)
        else $error("indicator lit after power fatal");

    property p_other_leds;
        @(posedge clk) disable iff (!rstn)
        (fatal && !pwrFatal_r) |-> ledPower && !ledRun && errorAlarmIndicator;
    endproperty
    a_other_leds: assert property (p_other_leds)
        else $error("wrong indicators for fatal");

    property p_pwr_code;
        @(posedge clk) disable iff (!rstn)
        (state_r == fes_pkg::FES_RUN && pwrLost) |=> pwrFatal_r && fatalCode == `FES_CODE_NONE;
    endproperty
    a_pwr_code: assert property (p_pwr_code)
        else $error("power fatal reported a code");

    property p_pwr_short;
        @(posedge clk) disable iff (!rstn)
        $rose(pwrSync_r) |=> pwrCnt_r == '0;
    endproperty
    a_pwr_short: assert property (p_pwr_short)
        else $error("gap timer not cleared");

    property p_mem_code;
        @(posedge clk) disable iff (!rstn)
        (state_r == fes_pkg::FES_RUN && !pwrLost && memFault) |=> fatalCode == `FES_CODE_MEM;
    endproperty
    a_mem_code: assert property (p_mem_code)
        else $error("memory fault code wrong");

    property p_flag_a;
        @(posedge clk) disable iff (!rstn)
        (variant_r == fes_pkg::FES_VAR_A && cassetteSwap) |=> memFlags_r[`FES_A_CASS];
    endproperty
    a_flag_a: assert property (p_flag_a)
        else $error("cassette flag not set");

    property p_flag_b;
        @(posedge clk) disable iff (!rstn)
        (variant_r == fes_pkg::FES_VAR_B && flashWearOut) |=> memFlags_r[`FES_B_FLASH];
    endproperty
    a_flag_b: assert property (p_flag_b)
        else $error("flash flag not set");

    property p_fatal_alarm_instruction_code;
        @(posedge clk) disable iff (!rstn)
        (state_r == fes_pkg::FES_RUN && falsOk && codeNxt == fatalAlarmOperand)
            |=> fatalCode == $past(fatalAlarmOperand);
    endproperty
    a_fatal_alarm_instruction_code: assert property (p_fatal_alarm_instruction_code)
        else $error("alarm operand not reported");

    property p_class;
        @(posedge clk) disable iff (!rstn)
        fatal |-> fatalClass == `FES_CLASS_FATAL;
    endproperty
    a_class: assert property (p_class)
        else $error("fatal class byte wrong");

    property p_hold;
        @(posedge clk) disable iff (!rstn)
        fatal |=> fatal && $stable(fatalCode);
    endproperty
    a_hold: assert property (p_hold)
        else $error("fatal state left without reset");

    property p_cyc;
        @(posedge clk) disable iff (!rstn)
        (state_r == fes_pkg::FES_RUN && cycOver && !pwrLost && !memFault
            && !missingTerminator && !ioBusErr && !ioWordOverflow)
            |=> fatalCode == `FES_CODE_CYC;
    endproperty
    a_cyc: assert property (p_cyc)
        else $error("cycle overrun code wrong");

endmodule

// ===== tb/fes_program_model.sv
// Program model: one cycle-start pulse per program cycle of cycleLen clocks
// Assumes the supervisor's runEnable; a zero length stops the program
`timescale 1ns/10ps

module fes_program_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic runEnable,
    input wire logic [15:0] cycleLen,
    output logic cycleStart
);
    logic [15:0] cnt_r;

    // A halted controller runs no further program cycles
    always_ff @(posedge clk) begin
        if (!rstn || !runEnable || cycleLen == 16'h0) begin
            cnt_r <= 16'h0;
            cycleStart <= 1'b0;
        end else begin
            cycleStart <= (cnt_r == 16'h0);
            cnt_r <= (cnt_r == cycleLen - 16'h1) ? 16'h0 : cnt_r + 16'h1;
        end
    end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the fatal-error supervisor
// Assumes fes_program_model beside it; power gap shortened to 20 clocks
`timescale 1ns/10ps
`include "fes_cfg.svh"
`define CHK(nm, ex, gt) begin totalChecks++; if ((gt) !== (ex)) begin errorCnt++; \
    $display("wrong value %s exp %0h got %0h", nm, ex, gt); end end

module testbench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic powerOk = 1'b1;
    logic cycleStart;
    logic [12:0] cause = 13'h0;
    logic [7:0] alarmOp = 8'h00;
    logic alarmGo = 1'b0;
    logic [15:0] cycleLen = 16'h0;
    logic [7:0] busLoc = 8'hA5;
    logic runEnable, outputsEnable, ledPower, ledRun, errAlm, fatal, irq;
    logic [7:0] fatalCode, fatalClass;
    int errorCnt = 0;
    int totalChecks = 0;
    localparam int IN_IDX[16] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 0, 1, 10, 11, 12, 11};
    localparam int FLG[16] = '{11, 12, 13, 14, 15, 8, 9, 10, 14, 15, 11, 12, 0, 0, 0, 0};
    localparam logic [7:0] CODE[4] = '{`FES_CODE_NOEND, `FES_CODE_IOBUS,
        `FES_CODE_IOOVR, `FES_CODE_IOBUS};
    localparam logic [7:0] OPS[4] = '{8'h01, 8'h99, 8'h00, 8'h1A};

    fes_supervisor #(.PWR_LOSS_CYC(20)) i_dut (
        .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .powerOk(powerOk), .cycleStart(cycleStart), .setupCsErr(cause[0]),
        .progCsErr(cause[1]), .expCsErr(cause[2]), .cassetteSwap(cause[3]),
        .cassetteReadErr(cause[4]), .undefBitArea(cause[5]), .flashWearOut(cause[6]),
        .roDataCsErr(cause[7]), .holdAreaLost(cause[8]), .remoteBusErr(cause[9]),
        .missingTerminator(cause[10]), .ioBusErr(cause[11]), .ioBusLoc(busLoc),
        .ioWordOverflow(cause[12]), .fatalAlarmInstruction(alarmGo),
        .fatalAlarmOperand(alarmOp), .runEnable(runEnable), .outputsEnable(outputsEnable),
        .ledPower(ledPower), .ledRun(ledRun), .errorAlarmIndicator(errAlm), .fatal(fatal),
        .fatalCode(fatalCode), .fatalClass(fatalClass), .irq(irq)
    );

    fes_program_model i_prog (
        .clk(clk), .rstn(rstn), .runEnable(runEnable), .cycleLen(cycleLen),
        .cycleStart(cycleStart)
    );

    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Entered just after an edge; holds the request until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (waitrequest !== 1'b0) begin
            errorCnt++;
            $display("wrong value waitrequest exp 0 got %b", waitrequest);
            report_and_stop();
        end
        @(posedge clk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] ex, input string nm);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        `CHK(nm, ex, q)
    endtask

    task automatic do_reset();
        rstn <= 1'b0;
        cause <= 13'h0;
        alarmGo <= 1'b0;
        powerOk <= 1'b1;
        cycleLen <= 16'h0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
    endtask

    task automatic pulse_cause(input int idx);
        cause[idx] <= 1'b1;
        @(posedge clk);
        cause <= 13'h0;
        repeat (3) @(posedge clk);
    endtask

    task automatic t_reset_values();
        `CHK("runEnable", 1'b1, runEnable)
        `CHK("fatalClass", `FES_CLASS_NONFATAL, fatalClass)
        rd_chk(`FES_OFS_CTRL, 32'h0, "ctrl");
        rd_chk(`FES_OFS_CYCLIM, 32'h0, "cyclim");
        rd_chk(`FES_OFS_STATUS, 32'h03000000, "status");
        rd_chk(`FES_OFS_IRQEN, 32'h0, "irqen");
        rd_chk(5'h02, 32'h0, "unmapped");
    endtask

    // Every memory, terminator, bus and overflow cause, both flag maps
    task automatic t_cause_table();
        logic [7:0] exCode;
        logic [31:0] exFlg;
        // Last row: bus fault in variant B keeps no location flags
        for (int r = 0; r < 16; r++) begin
            do_reset();
            if ((r >= 5 && r <= 11) || r == 15) begin
                wr(`FES_OFS_CTRL, 32'h1);
                rd_chk(`FES_OFS_CTRL, 32'h1, "ctrl");
            end
            exCode = (r < 12) ? `FES_CODE_MEM : CODE[r - 12];
            exFlg = (r < 12) ? 32'h1 << FLG[r] : 32'h0;
            pulse_cause(IN_IDX[r]);
            `CHK("fatalCode", exCode, fatalCode)
            `CHK("outputsEnable", 1'b0, outputsEnable)
            `CHK("runEnable", 1'b0, runEnable)
            `CHK("ledPower", 1'b1, ledPower)
            `CHK("ledRun", 1'b0, ledRun)
            `CHK("errAlm", 1'b1, errAlm)
            `CHK("fatalClass", `FES_CLASS_FATAL, fatalClass)
            rd_chk(`FES_OFS_MEMFLG, exFlg, "memflg");
            rd_chk(`FES_OFS_IOLOC, (r == 13) ? 32'h0000A500 : 32'h0, "ioloc");
        end
    endtask

    task automatic t_alarm();
        for (int i = 0; i < 4; i++) begin
            do_reset();
            alarmOp <= OPS[i];
            alarmGo <= 1'b1;
            @(posedge clk);
            alarmGo <= 1'b0;
            repeat (3) @(posedge clk);
            `CHK("fatal", (i < 2), fatal)
            `CHK("fatalCode", (i < 2) ? OPS[i] : 8'h00, fatalCode)
        end
        do_reset();
        alarmOp <= 8'h99;
        alarmGo <= 1'b1;
        @(posedge clk);
        alarmGo <= 1'b0;
        pulse_cause(10);
        repeat (100) @(posedge clk);
        `CHK("fatalCode", 8'h99, fatalCode)
        `CHK("outputsEnable", 1'b0, outputsEnable)
    endtask

    task automatic t_power();
        do_reset();
        powerOk <= 1'b0;
        repeat (10) @(posedge clk);
        powerOk <= 1'b1;
        repeat (10) @(posedge clk);
        `CHK("fatal", 1'b0, fatal)
        powerOk <= 1'b0;
        repeat (60) @(posedge clk);
        powerOk <= 1'b1;
        repeat (5) @(posedge clk);
        `CHK("outputsEnable", 1'b0, outputsEnable)
        `CHK("fatalCode", `FES_CODE_NONE, fatalCode)
        rd_chk(`FES_OFS_STATUS, 32'h00800003, "status");
        rd_chk(`FES_OFS_IRQST, 32'h3, "irqst");
    endtask

    task automatic t_cycle();
        int n;
        do_reset();
        wr(`FES_OFS_CYCLIM, 32'h2);
        rd_chk(`FES_OFS_CYCLIM, 32'h2, "cyclim");
        cycleLen <= 16'h00C8;
        repeat (2000) @(posedge clk);
        `CHK("fatal", 1'b0, fatal)
        cycleLen <= 16'h03E8;
        n = 0;
        while (fatal !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (fatal !== 1'b1) begin
            errorCnt++;
            $display("wrong value fatal exp 1 got %b", fatal);
            report_and_stop();
        end
        `CHK("fatalCode", `FES_CODE_CYC, fatalCode)
    endtask

    task automatic t_irq();
        do_reset();
        wr(`FES_OFS_IRQEN, 32'h1);
        pulse_cause(10);
        `CHK("irq", 1'b1, irq)
        wr(`FES_OFS_STATUS, 32'h0);
        rd_chk(`FES_OFS_STATUS, 32'h0580F001, "status");
        wr(`FES_OFS_IRQEN, 32'h0);
        `CHK("irq", 1'b0, irq)
        wr(`FES_OFS_IRQEN, 32'h1);
        wr(`FES_OFS_IRQCLR, 32'h1);
        `CHK("irq", 1'b0, irq)
        rd_chk(`FES_OFS_IRQST, 32'h0, "irqst");
        `CHK("fatal", 1'b1, fatal)
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset_values();
        t_cause_table();
        t_alarm();
        t_power();
        t_cycle();
        t_irq();
        report_and_stop();
    end
endmodule
